// ---- rtl/rcpt_pkg.sv ----
// Constants and command codes for the maintenance timing controller
package rcpt_pkg;

  typedef enum logic [3:0] {
    CMD_NOP,
    CMD_REF_ALL,
    CMD_REF_INC,
    CMD_ROW_CLOSE,
    CMD_REF_CLOSE,
    CMD_OTHER,
    CMD_CAL_CUR,
    CMD_CAL_IMP,
    CMD_CAL_END,
    CMD_PDN_ENTER,
    CMD_PDN_EXIT
  } rcpt_cmd_e;

  localparam int CLK_PERIOD_NS = 8;
  localparam int CORE_INIT_NS = 1500000;
  localparam int CORE_INIT_CYC = (CORE_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_AVG_NS = 488;
  localparam int REF_AVG_CYC = REF_AVG_NS / CLK_PERIOD_NS;

  localparam int REF_BURST_MAX = 128;
  localparam int REF_BURST_GAP = 40;
  localparam int CAL_GAP_CLOSE = 4;
  localparam int CAL_GAP_OTHER = 16;
  localparam int CAL_TO_END = 12;
  localparam int CAL_END_TO_CMD = 24;
  localparam int CMD_TO_PDN = 16;
  localparam int PDN_CLK_HOLD = 16;
  localparam int CLK_TO_PDN_EXIT = 16;
  localparam int PDN_LOCK = 4096;

  localparam int HALF_DIV = 4;
  localparam int DIV_W = 4;
  localparam int LINK_W = 13;
  localparam int INIT_W = 18;
  localparam int REFT_W = 8;
  localparam int BURST_W = 8;
  localparam int DEBT_W = 6;

endpackage : rcpt_pkg

// ---- rtl/rcpt_sat_counter.sv ----
// Saturating event counter with restart
`timescale 1ns/1ns
module rcpt_sat_counter #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic en,
  output logic [W-1:0] count
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  wire logic atMax = &count_q;

  // A restart on a counting edge already counts that edge
  assign count_d = clr ? {{(W-1){1'b0}}, en} : ((en && !atMax) ? count_q + 1'b1 : count_q);
  assign count = count_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule : rcpt_sat_counter

// ---- rtl/rcpt_host.sv ----
// Controller that spaces refresh, calibration and low-power traffic on the request link
`timescale 1ns/1ns
module rcpt_host #(
  parameter int CORE_INIT_CYC = rcpt_pkg::CORE_INIT_CYC,
  parameter int HALF_DIV = rcpt_pkg::HALF_DIV
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmdValid,
  input wire rcpt_pkg::rcpt_cmd_e cmdCode,
  output logic cmdAccept_q,
  output logic coreReady_q,
  output logic refreshDue_q,
  output logic reqClkTrue_q,
  output logic reqClkComp_q,
  output logic pktValid_q,
  output rcpt_pkg::rcpt_cmd_e pktCode_q,
  output logic lowPower_q
);

  typedef enum logic [2:0] {S_INIT, S_RUN, S_CAL, S_PDN, S_WAKE, S_LOCK} rcpt_state_e;
  localparam int LW = rcpt_pkg::LINK_W;

  rcpt_state_e state_q, state_d;
  logic [rcpt_pkg::DIV_W-1:0] divCnt_q;
  logic phase_q, clkRun_q, lastClose_q;
  logic [rcpt_pkg::BURST_W-1:0] burstCnt_q;
  logic [rcpt_pkg::REFT_W-1:0] refTimer_q;
  logic [rcpt_pkg::DEBT_W-1:0] debt_q;
  logic [LW-1:0] sinceCmd, sinceRef, sinceCale, phaseCnt;
  logic [rcpt_pkg::INIT_W-1:0] initCnt;

  // Request clock: divided from clk, packets launch as it falls
  wire logic divWrap = divCnt_q == rcpt_pkg::DIV_W'(HALF_DIV - 1);
  wire logic tick = divWrap && phase_q;
  wire logic phaseNext = divWrap ? !phase_q : phase_q;

  // Command classes
  wire logic userRef = cmdCode == rcpt_pkg::CMD_REF_ALL || cmdCode == rcpt_pkg::CMD_REF_INC;
  wire logic userCal = cmdCode == rcpt_pkg::CMD_CAL_CUR || cmdCode == rcpt_pkg::CMD_CAL_IMP;
  wire logic userStray = cmdCode == rcpt_pkg::CMD_CAL_END || cmdCode == rcpt_pkg::CMD_PDN_EXIT
                      || cmdCode == rcpt_pkg::CMD_NOP;
  wire logic userPdn = cmdCode == rcpt_pkg::CMD_PDN_ENTER;

  // Spacing checks, in link cycles except initDone, which counts clk cycles, and the burst limit in refOk, which counts refreshes
  wire logic refGapOk = sinceRef >= LW'(rcpt_pkg::REF_BURST_GAP);
  wire logic refOk = (burstCnt_q < rcpt_pkg::BURST_W'(rcpt_pkg::REF_BURST_MAX)) || refGapOk;
  wire logic caleOk = sinceCale >= LW'(rcpt_pkg::CAL_END_TO_CMD);
  wire logic calOk = sinceCmd >= (lastClose_q ? LW'(rcpt_pkg::CAL_GAP_CLOSE)
                                              : LW'(rcpt_pkg::CAL_GAP_OTHER));
  wire logic pdnOk = sinceCmd >= LW'(rcpt_pkg::CMD_TO_PDN);
  wire logic calEndOk = phaseCnt >= LW'(rcpt_pkg::CAL_TO_END);
  wire logic clkHoldDone = phaseCnt >= LW'(rcpt_pkg::PDN_CLK_HOLD);
  wire logic wakeDone = phaseCnt >= LW'(rcpt_pkg::CLK_TO_PDN_EXIT);
  wire logic lockDone = phaseCnt >= LW'(rcpt_pkg::PDN_LOCK);
  wire logic initDone = initCnt >= rcpt_pkg::INIT_W'(CORE_INIT_CYC);

  wire logic runOk = userStray || (userRef ? (refOk && caleOk)
                   : userCal ? (calOk && caleOk)
                   : userPdn ? pdnOk : caleOk);
  wire logic userOk = (state_q == S_RUN && runOk)
                   || (state_q == S_CAL && cmdCode == rcpt_pkg::CMD_CAL_END && calEndOk)
                   || (state_q == S_PDN && cmdCode == rcpt_pkg::CMD_PDN_EXIT && clkHoldDone);

  // Owed refreshes go first so user traffic cannot starve them
  wire logic intRef = state_q == S_RUN && debt_q != '0 && refOk && caleOk;
  wire logic take = tick && !intRef && cmdValid && userOk;
  wire logic dropIt = state_q == S_RUN && userStray;
  wire logic pdnExit = state_q == S_PDN;
  wire logic sendPkt = tick && (intRef || (take && !dropIt && !pdnExit));
  wire rcpt_pkg::rcpt_cmd_e code = intRef ? rcpt_pkg::CMD_REF_INC : cmdCode;
  wire logic isRef = code == rcpt_pkg::CMD_REF_ALL || code == rcpt_pkg::CMD_REF_INC;
  wire logic isMaint = code == rcpt_pkg::CMD_CAL_CUR || code == rcpt_pkg::CMD_CAL_IMP
                    || code == rcpt_pkg::CMD_CAL_END || code == rcpt_pkg::CMD_PDN_ENTER;
  wire logic carriesCmd = sendPkt && !isMaint;
  wire logic isClose = code == rcpt_pkg::CMD_ROW_CLOSE || code == rcpt_pkg::CMD_REF_CLOSE;
  wire logic refSent = sendPkt && isRef;

  // Refresh pacing: one refresh owed per average interval, self-refresh covers low power
  wire logic paceRun = state_q == S_RUN || state_q == S_CAL;
  wire logic refTimerWrap = refTimer_q == rcpt_pkg::REFT_W'(rcpt_pkg::REF_AVG_CYC - 1);
  wire logic debtUp = paceRun && refTimerWrap && !(&debt_q);
  wire logic debtDown = refSent && debt_q != '0;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_INIT: if (initDone) state_d = S_RUN;
      S_RUN: begin
        if (sendPkt && (code == rcpt_pkg::CMD_CAL_CUR || code == rcpt_pkg::CMD_CAL_IMP)) begin
          state_d = S_CAL;
        end else if (sendPkt && code == rcpt_pkg::CMD_PDN_ENTER) begin
          state_d = S_PDN;
        end
      end
      S_CAL: if (sendPkt) state_d = S_RUN;
      S_PDN: if (take) state_d = S_WAKE;
      S_WAKE: if (tick && wakeDone) state_d = S_LOCK;
      S_LOCK: if (tick && lockDone) state_d = S_RUN;
    endcase
  end

  rcpt_sat_counter #(.W(rcpt_pkg::INIT_W)) uInit (
    .clk(clk), .nrst(nrst), .clr(1'b0), .en(state_q == S_INIT), .count(initCnt));
  rcpt_sat_counter #(.W(LW)) uSinceCmd (
    .clk(clk), .nrst(nrst), .clr(carriesCmd), .en(tick), .count(sinceCmd));
  rcpt_sat_counter #(.W(LW)) uSinceRef (
    .clk(clk), .nrst(nrst), .clr(refSent), .en(tick), .count(sinceRef));
  rcpt_sat_counter #(.W(LW)) uSinceCale (
    .clk(clk), .nrst(nrst), .clr(sendPkt && code == rcpt_pkg::CMD_CAL_END), .en(tick),
    .count(sinceCale));
  rcpt_sat_counter #(.W(LW)) uPhase (
    .clk(clk), .nrst(nrst), .clr(state_d != state_q), .en(tick), .count(phaseCnt));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      divCnt_q <= '0;
      phase_q <= 1'b0;
      reqClkTrue_q <= 1'b0;
      reqClkComp_q <= 1'b1;
    end else begin
      divCnt_q <= divWrap ? '0 : divCnt_q + 1'b1;
      phase_q <= phaseNext;
      // Run changes only while the clock is low, so no runt pulse
      reqClkTrue_q <= clkRun_q && phaseNext;
      reqClkComp_q <= !(clkRun_q && phaseNext);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= S_INIT;
      clkRun_q <= 1'b1;
      lowPower_q <= 1'b0;
      coreReady_q <= 1'b0;
    end else begin
      state_q <= state_d;
      coreReady_q <= coreReady_q || (state_q == S_INIT && initDone);
      if (state_q == S_PDN && tick && clkHoldDone) clkRun_q <= 1'b0;
      if (state_q == S_PDN && take) clkRun_q <= 1'b1;
      if (state_q == S_RUN && state_d == S_PDN) lowPower_q <= 1'b1;
      if (state_q == S_WAKE && state_d == S_LOCK) lowPower_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pktValid_q <= 1'b0;
      pktCode_q <= rcpt_pkg::CMD_NOP;
      cmdAccept_q <= 1'b0;
      lastClose_q <= 1'b0;
    end else begin
      cmdAccept_q <= take;
      // A packet stands for one whole link cycle
      if (tick) begin
        pktValid_q <= sendPkt;
        pktCode_q <= sendPkt ? code : rcpt_pkg::CMD_NOP;
      end
      if (carriesCmd) lastClose_q <= isClose;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      burstCnt_q <= '0;
      refTimer_q <= '0;
      debt_q <= '0;
      refreshDue_q <= 1'b0;
    end else begin
      if (refSent) begin
        burstCnt_q <= refGapOk ? rcpt_pkg::BURST_W'(1) : burstCnt_q + 1'b1;
      end
      refTimer_q <= (refTimerWrap || !paceRun) ? '0 : refTimer_q + 1'b1;
      // Debt clears on leaving lock; otherwise intervals add to it and sent refreshes repay it
      if (state_q == S_LOCK && state_d == S_RUN) begin
        debt_q <= '0;
      end else if (debtUp && !debtDown) begin
        debt_q <= debt_q + 1'b1;
      end else if (debtDown && !debtUp) begin
        debt_q <= debt_q - 1'b1;
      end
      refreshDue_q <= debt_q != '0;
    end
  end

endmodule : rcpt_host

// ---- sim/rcpt_host_monitor.sv ----
// Checker for maintenance spacing on the request link
`timescale 1ns/1ns
module rcpt_host_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic coreReady_q,
  input wire logic reqClkTrue_q,
  input wire logic pktValid_q,
  input wire rcpt_pkg::rcpt_cmd_e pktCode_q,
  input wire logic lowPower_q
);
  logic prevTrue_q, prevLow_q, lastClose_q;
  int sinceCmd_q, sinceCal_q, sinceEnd_q, sinceRef_q, sinceExit_q, burst_q;
  int idleCnt_q, runCnt_q, pdnTicks_q;
  wire tk = prevTrue_q & ~reqClkTrue_q;
  wire newPkt = tk & pktValid_q;
  wire isCmd = newPkt && pktCode_q inside {[rcpt_pkg::CMD_REF_ALL:rcpt_pkg::CMD_OTHER]};
  wire isRef = newPkt && pktCode_q inside {rcpt_pkg::CMD_REF_ALL, rcpt_pkg::CMD_REF_INC};
  wire isCal = newPkt && pktCode_q inside {rcpt_pkg::CMD_CAL_CUR, rcpt_pkg::CMD_CAL_IMP};
  wire isEnd = newPkt && pktCode_q == rcpt_pkg::CMD_CAL_END;
  wire isPdn = newPkt && pktCode_q == rcpt_pkg::CMD_PDN_ENTER;
  wire isClose = pktCode_q inside {rcpt_pkg::CMD_ROW_CLOSE, rcpt_pkg::CMD_REF_CLOSE};
  // Gaps other than sinceCal_q start large so the first packets after reset are not held to a spacing
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {prevTrue_q, prevLow_q, lastClose_q} <= 3'h0;
      {sinceCmd_q, sinceEnd_q, sinceRef_q, sinceExit_q} <= {4{32'd9999}};
      {sinceCal_q, burst_q, idleCnt_q, runCnt_q, pdnTicks_q} <= '0;
    end else begin
      prevTrue_q <= reqClkTrue_q;
      prevLow_q <= lowPower_q;
      idleCnt_q <= tk ? 0 : idleCnt_q + 1;
      sinceExit_q <= (prevLow_q & ~lowPower_q) ? 0 : sinceExit_q + int'(tk);
      if (tk) begin
        sinceCmd_q <= isCmd ? 0 : sinceCmd_q + 1;
        lastClose_q <= isCmd ? isClose : lastClose_q;
        sinceCal_q <= isCal ? 0 : sinceCal_q + 1;
        sinceEnd_q <= isEnd ? 0 : sinceEnd_q + 1;
        sinceRef_q <= isRef ? 0 : sinceRef_q + 1;
        burst_q <= !isRef ? burst_q : (sinceRef_q >= 39 ? 1 : burst_q + 1);
        runCnt_q <= idleCnt_q > 8 ? 1 : runCnt_q + 1;
        pdnTicks_q <= lowPower_q ? pdnTicks_q + 1 : 0;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_core_wait: assert property (!coreReady_q |-> !pktValid_q) else $error("early packet");
  a_burst_limit: assert property (isRef |-> burst_q < 128 || sinceRef_q >= 39)
    else $error("refresh burst too long");
  a_cal_after_cmd: assert property (isCal |-> sinceCmd_q >= (lastClose_q ? 3 : 15))
    else $error("calibration too soon");
  a_cal_to_end: assert property (isEnd |-> sinceCal_q >= 11) else $error("end too soon");
  a_cmd_after_end: assert property (isCmd |-> sinceEnd_q >= 23)
    else $error("command too soon after end");
  // Entry raises lowPower_q on the packet's own tick, so it is seen rising with the packet
  a_pdn_entry_gap: assert property (isPdn |-> sinceCmd_q >= 15 && $rose(lowPower_q))
    else $error("low power entry too soon");
  a_clock_after_pdn: assert property (lowPower_q && pdnTicks_q < 16 |-> ##[1:8] tk)
    else $error("clock stopped early");
  // The sixteenth fall lands with the exit, so only fifteen are already counted
  a_clock_before_exit: assert property ($fell(lowPower_q) |-> runCnt_q >= 15)
    else $error("exit before clock stable");
  a_lock_wait: assert property (isCmd |-> sinceExit_q >= 4095) else $error("lock too short");
endmodule : rcpt_host_monitor

// ---- sim/rcpt_dev_model.sv ----
// Device model: its core wakes after a fixed interval and flags earlier commands
`timescale 1ns/1ns
module rcpt_dev_model #(
  parameter int INIT_CYC = 50
) (
  input wire logic clk,
  input wire logic reqClk,
  input wire logic pktValid,
  output int errCount
);
  int upCnt = 0;
  logic prevClk = 1'h0;
  initial errCount = 0;
  always @(posedge clk) begin
    prevClk <= reqClk;
    if (upCnt < INIT_CYC) upCnt <= upCnt + 1;
    if (prevClk && !reqClk && pktValid && upCnt < INIT_CYC) errCount <= errCount + 1;
  end
endmodule : rcpt_dev_model

// ---- sim/rcpt_host_bench.sv ----
// Bench for the maintenance timing controller
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module rcpt_host_bench;
  logic clk = 1'h0, nrst = 1'h0, cmdValid = 1'h0, prevT = 1'h0;
  rcpt_pkg::rcpt_cmd_e cmdCode = rcpt_pkg::CMD_NOP, pktCode_q;
  logic cmdAccept_q, coreReady_q, refreshDue_q, reqClkTrue_q, reqClkComp_q, pktValid_q, lowPower_q;
  int bad_count = 0, n_checks = 0, ticks = 0, incCnt = 0, devErr, t0, t1, t2;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    prevT <= reqClkTrue_q;
    if (prevT && !reqClkTrue_q) ticks <= ticks + 1;
    if (prevT && !reqClkTrue_q && pktValid_q && pktCode_q == rcpt_pkg::CMD_REF_INC) incCnt++;
  end
  rcpt_host #(.CORE_INIT_CYC(50)) dut_u (.clk(clk), .nrst(nrst), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .cmdAccept_q(cmdAccept_q), .coreReady_q(coreReady_q),
    .refreshDue_q(refreshDue_q), .reqClkTrue_q(reqClkTrue_q), .reqClkComp_q(reqClkComp_q),
    .pktValid_q(pktValid_q), .pktCode_q(pktCode_q), .lowPower_q(lowPower_q));
  rcpt_dev_model #(.INIT_CYC(50)) dev_u (.clk(clk), .reqClk(reqClkTrue_q),
    .pktValid(pktValid_q), .errCount(devErr));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // Holds the request until taken; returns the link tick of its packet
  task automatic send(input rcpt_pkg::rcpt_cmd_e c, output int t);
    int i;
    @(posedge clk);
    #1 cmdValid = 1'h1;
    cmdCode = c;
    for (i = 0; i < 40000 && cmdAccept_q !== 1'h1; i++) @(posedge clk);
    if (i == 40000) begin
      bad_count++;
      end_of_test();
    end
    t = ticks;
    #1 cmdValid = 1'h0;
  endtask : send
  task automatic t_init();
    send(rcpt_pkg::CMD_REF_ALL, t0);
    `CHK(coreReady_q, 1'h1)
  endtask : t_init
  task automatic t_cal();
    send(rcpt_pkg::CMD_ROW_CLOSE, t0);
    send(rcpt_pkg::CMD_CAL_CUR, t1);
    `CHK(t1 - t0 >= 4, 1'h1)
    send(rcpt_pkg::CMD_CAL_END, t2);
    `CHK(t2 - t1 >= 12, 1'h1)
    send(rcpt_pkg::CMD_OTHER, t0);
    `CHK(t0 - t2 >= 24, 1'h1)
    send(rcpt_pkg::CMD_CAL_IMP, t1);
    `CHK(t1 - t0 >= 16, 1'h1)
    send(rcpt_pkg::CMD_CAL_END, t2);
  endtask : t_cal
  // 130 refreshes cannot fit in 167 ticks once the burst limit forces a gap
  task automatic t_burst();
    for (int i = 0; i < 130; i++) begin
      send(i[0] ? rcpt_pkg::CMD_REF_INC : rcpt_pkg::CMD_REF_ALL, t1);
      if (i == 0) t0 = t1;
    end
    `CHK(t1 - t0 >= 168, 1'h1)
  endtask : t_burst
  task automatic t_rate();
    int seen;
    seen = 0;
    t0 = incCnt;
    repeat (610) begin
      @(posedge clk);
      if (refreshDue_q === 1'h1) seen++;
    end
    `CHK(incCnt - t0 >= 9, 1'h1)
    `CHK(seen > 0, 1'h1)
  endtask : t_rate
  task automatic t_pdn();
    send(rcpt_pkg::CMD_OTHER, t0);
    send(rcpt_pkg::CMD_PDN_ENTER, t1);
    `CHK(t1 - t0 >= 16, 1'h1)
    repeat (300) @(posedge clk);
    `CHK(lowPower_q, 1'h1)
    `CHK(ticks - t1 >= 16, 1'h1)
    `CHK(reqClkComp_q, 1'h1)
    send(rcpt_pkg::CMD_PDN_EXIT, t0);
    send(rcpt_pkg::CMD_REF_ALL, t2);
    `CHK(t2 - t0 >= 4112, 1'h1)
    `CHK(lowPower_q, 1'h0)
  endtask : t_pdn
  initial begin
    repeat (20) @(posedge clk);
    #1 nrst = 1'h1;
    t_init();
    t_cal();
    t_burst();
    t_rate();
    t_pdn();
    `CHK(devErr, 0)
    end_of_test();
  end
endmodule : rcpt_host_bench
bind rcpt_host rcpt_host_monitor mon_u (.clk(clk), .nrst(nrst), .coreReady_q(coreReady_q),
  .reqClkTrue_q(reqClkTrue_q), .pktValid_q(pktValid_q), .pktCode_q(pktCode_q),
  .lowPower_q(lowPower_q));
